// [ddrini_pkg.sv]
// What this block does
// - hold clock enable low while a stable memory clock runs after power-up
// - wait at least 200 us with clock enable low before any step
// - raise clock enable, send at least one no-operation before first precharge-all
// - precharge-all then row precharge time with only no-operations
// - load extended mode: loop enabled, drive strength selectable, higher bits zero
// - after each mode load wait mode-register delay with only no-operations
// - load base mode with loop reset bit high to reset the loop
// - at least 200 cycles from loop reset to first read; a read requested as a re-lock starts is granted alongside that loop reset
// - second precharge-all then row precharge time with only no-operations
// - two auto refreshes, each followed by refresh cycle time of no-operations
// - refreshes may be placed before the second precharge-all
// - optional base mode reload with loop reset clear, same parameters, then delay
// - lower strobe qualifies data bits 0-7, upper strobe bits 8-15 (the strobes are outside this block)
// - on clock change reset the loop again and wait 200 cycles before reads; a read requested as the re-lock starts is granted alongside the loop reset
package ddrini_pkg;

  // apb register map
  localparam logic [11:0] DDRINI_CTRL_OFF = 12'h000;
  localparam logic [11:0] DDRINI_MODE_OFF = 12'h004;
  localparam logic [11:0] DDRINI_STAT_OFF = 12'h008;
  // control bit positions
  localparam int DDRINI_CTRL_START   = 0;
  localparam int DDRINI_CTRL_DRIVE   = 1;
  localparam int DDRINI_CTRL_REFEARLY = 2;
  localparam int DDRINI_CTRL_RELOAD  = 3;
  localparam int DDRINI_CTRL_RELOCK  = 4;
  localparam logic [12:0] DDRINI_MODE_RST = 13'h0022;
  // address bit that resets the delay-locked loop in the base mode load
  localparam int DDRINI_LOOP_RESET_BIT = 8;
  localparam int DDRINI_PRECH_ALL_BIT  = 10;

  // timing, 20 MHz core clock
  localparam int DDRINI_CLK_NS     = 50;
  localparam int DDRINI_PWRUP_US   = 200;
  localparam int DDRINI_PWRUP_CYC  = (DDRINI_PWRUP_US * 1000 + DDRINI_CLK_NS - 1) / DDRINI_CLK_NS;
  localparam int DDRINI_TRP_NS     = 20;
  localparam int DDRINI_TRP_CYC    = (DDRINI_TRP_NS + DDRINI_CLK_NS - 1) / DDRINI_CLK_NS;
  localparam int DDRINI_TMRD_NS    = 15;
  localparam int DDRINI_TMRD_CYC   = (DDRINI_TMRD_NS + DDRINI_CLK_NS - 1) / DDRINI_CLK_NS;
  localparam int DDRINI_TRFC_NS    = 75;
  localparam int DDRINI_TRFC_CYC   = (DDRINI_TRFC_NS + DDRINI_CLK_NS - 1) / DDRINI_CLK_NS;
  localparam int DDRINI_NOP_CYC    = 1;
  localparam int DDRINI_LOCK_CYC   = 200;

  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] DDRINI_CMD_NOP = 4'h7;
  localparam logic [3:0] DDRINI_CMD_PRE = 4'h2;
  localparam logic [3:0] DDRINI_CMD_REF = 4'h1;
  localparam logic [3:0] DDRINI_CMD_LMR = 4'h0;

  typedef struct packed {
    logic [3:0]  cmd;
    logic [1:0]  bank;
    logic [12:0] addr;
  } ddrini_cmd_s;

  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,
    ST_PWRUP = 11'h002,
    ST_NOP   = 11'h004,
    ST_PRE1  = 11'h008,
    ST_EMR   = 11'h010,
    ST_MR    = 11'h020,
    ST_PRE2  = 11'h040,
    ST_REF   = 11'h080,
    ST_MR2   = 11'h100,
    ST_WAIT  = 11'h200,
    ST_DONE  = 11'h400
  } ddrini_state_e;

endpackage : ddrini_pkg

// [ddrini_cnt.sv]
// down counter for timing waits; the zero flag is decoded from the count register, not registered itself
module ddrini_cnt
  import ddrini_pkg::*;
(
  input  wire logic        i_core_clk, // core clock
  input  wire logic        i_rst,      // sync reset, high
  input  wire logic        i_load,     // load a new count
  input  wire logic [22:0] i_value,    // cycles to wait
  output logic             o_zero      // count expired
);
  logic [22:0] cnt_ff;

  // load wins over decrement
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_ff <= 23'h000000;
    end else if (i_load) begin
      cnt_ff <= i_value;
    end else if (cnt_ff != 23'h000000) begin
      cnt_ff <= cnt_ff - 23'h000001;
    end
  end

  assign o_zero = (cnt_ff == 23'h000000);
endmodule : ddrini_cnt

// [ddrini_ctrl.sv]
// power-up sequencer for a ddr memory, programmed over apb
//
// The APB slave port and the register offsets were chosen for this implementation.
module ddrini_ctrl
  import ddrini_pkg::*;
#(
  parameter int PWRUP_CYC = DDRINI_PWRUP_CYC // shorten in simulation
)(
  input  wire logic        i_core_clk,   // core clock
  input  wire logic        i_rst,        // sync reset, high
  input  wire logic        i_psel,       // apb select
  input  wire logic        i_penable,    // apb enable
  input  wire logic        i_pwrite,     // apb write
  input  wire logic [11:0] i_paddr,      // apb byte address
  input  wire logic [31:0] i_pwdata,     // apb write data
  output logic [31:0]      o_prdata,     // apb read data
  output logic             o_pready,     // apb ready
  output logic             o_pslverr,    // apb error
  input  wire logic        i_user_req,   // user activate/read/write request
  input  wire logic        i_user_rd,    // request is a read
  output logic             o_user_gnt,   // request granted
  output logic             o_ready,      // init finished
  output logic             o_mem_cke,    // memory clock enable
  output logic             o_mem_clk_en, // run memory clock
  output ddrini_cmd_s      o_mem_cmd     // command, bank, address
);
  ddrini_state_e state_ff, nxt_state;
  logic          drive_ff, refearly_ff, reload_ff;
  logic [12:0]   mode_ff;
  logic          start_ff;
  logic [1:0]    ref_cnt_ff;
  logic          pre2_done_ff;
  logic [7:0]    lock_ff;
  logic          cnt_load;
  logic [22:0]   cnt_val;
  logic          cnt_zero;
  ddrini_cmd_s   nxt_cmd;
  logic          apb_wr;

  // a write lands in the access phase, at the edge where pready is seen high
  assign apb_wr = i_psel & i_penable & i_pwrite;

  // apb slave answers every access in its first access cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & (i_paddr != DDRINI_CTRL_OFF) & (i_paddr != DDRINI_MODE_OFF)
                   & (i_paddr != DDRINI_STAT_OFF);
      o_prdata  <= 32'h00000000;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        case (i_paddr)
          DDRINI_CTRL_OFF: o_prdata <= {27'h0, 1'b0, reload_ff, refearly_ff, drive_ff, 1'b0};
          DDRINI_MODE_OFF: o_prdata <= {19'h0, mode_ff};
          DDRINI_STAT_OFF: o_prdata <= {20'h0, lock_ff == 8'h00, o_ready, state_ff[9:0]};
          default:         o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // writable configuration; mode register is locked while sequencing
  // a start written mid-sequence is only looked at in idle or done, so it cannot restart a wait
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      drive_ff    <= 1'b0;
      refearly_ff <= 1'b0;
      reload_ff   <= 1'b0;
      mode_ff     <= DDRINI_MODE_RST;
      start_ff    <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (apb_wr && addr_hit(i_paddr, DDRINI_CTRL_OFF)) begin
        drive_ff    <= i_pwdata[DDRINI_CTRL_DRIVE];
        refearly_ff <= i_pwdata[DDRINI_CTRL_REFEARLY];
        reload_ff   <= i_pwdata[DDRINI_CTRL_RELOAD];
        start_ff    <= i_pwdata[DDRINI_CTRL_START] | i_pwdata[DDRINI_CTRL_RELOCK];
      end
      if (apb_wr && addr_hit(i_paddr, DDRINI_MODE_OFF) && state_ff inside {ST_IDLE, ST_DONE}) begin
        mode_ff <= i_pwdata[12:0];
      end
    end
  end

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] b);
    addr_hit = (a == b);
  endfunction : addr_hit

  ddrini_cnt u_cnt (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_load     (cnt_load),
    .i_value    (cnt_val),
    .o_zero     (cnt_zero)
  );

  // sequencer: issue one command, then count its gap on the wait counter
  // the gap runs from the command edge, so each wait is one cycle longer than its count
  always_comb begin
    nxt_state = state_ff;
    nxt_cmd   = '{cmd: DDRINI_CMD_NOP, bank: 2'b00, addr: 13'h0000};
    cnt_load  = 1'b0;
    cnt_val   = 23'h000000;
    case (state_ff)
      ST_IDLE: begin
        if (start_ff) begin
          nxt_state = ST_PWRUP;
          cnt_load  = 1'b1;
          cnt_val   = 23'(PWRUP_CYC);
        end
      end
      // memory clock runs, cke held low for the whole power-up wait
      ST_PWRUP: begin
        if (cnt_zero) begin
          nxt_state = ST_NOP;                              // cke rises here
          cnt_load  = 1'b1;
          cnt_val   = 23'(DDRINI_NOP_CYC);
        end
      end
      ST_NOP: begin
        if (cnt_zero) begin
          nxt_state = ST_PRE1;
          nxt_cmd.cmd = DDRINI_CMD_PRE;
          nxt_cmd.addr[DDRINI_PRECH_ALL_BIT] = 1'b1;
          cnt_load  = 1'b1;
          cnt_val   = 23'(DDRINI_TRP_CYC);
        end
      end
      ST_PRE1: begin
        if (cnt_zero) begin
          nxt_state = ST_EMR;
          nxt_cmd.cmd  = DDRINI_CMD_LMR;
          nxt_cmd.bank = 2'b01;
          nxt_cmd.addr = {11'h000, drive_ff, 1'b0};
          cnt_load  = 1'b1;
          cnt_val   = 23'(DDRINI_TMRD_CYC);
        end
      end
      // extended mode is in, now the base mode with the loop reset bit
      ST_EMR: begin
        if (cnt_zero) begin
          nxt_state = ST_MR;
          nxt_cmd.cmd  = DDRINI_CMD_LMR;
          nxt_cmd.addr = mode_ff;
          nxt_cmd.addr[DDRINI_LOOP_RESET_BIT] = 1'b1;
          cnt_load  = 1'b1;
          cnt_val   = 23'(DDRINI_TMRD_CYC);
        end
      end
      ST_MR: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (pre2_done_ff) begin                          // re-lock: banks idle, no precharge or refresh
            nxt_state = ST_WAIT;
          end else if (refearly_ff) begin
            nxt_state   = ST_REF;
            nxt_cmd.cmd = DDRINI_CMD_REF;
            cnt_val     = 23'(DDRINI_TRFC_CYC);
          end else begin
            nxt_state   = ST_PRE2;
            nxt_cmd.cmd = DDRINI_CMD_PRE;
            nxt_cmd.addr[DDRINI_PRECH_ALL_BIT] = 1'b1;
            cnt_val     = 23'(DDRINI_TRP_CYC);
          end
        end
      end
      // second precharge gap, or the finish once both refreshes are done
      ST_PRE2: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (ref_cnt_ff != 2'd2) begin
            nxt_state   = ST_REF;
            nxt_cmd.cmd = DDRINI_CMD_REF;
            cnt_val     = 23'(DDRINI_TRFC_CYC);
          end else if (reload_ff) begin
            nxt_state    = ST_MR2;
            nxt_cmd.cmd  = DDRINI_CMD_LMR;
            nxt_cmd.addr = mode_ff;
            nxt_cmd.addr[DDRINI_LOOP_RESET_BIT] = 1'b0;
            cnt_val      = 23'(DDRINI_TMRD_CYC);
          end else begin
            nxt_state = ST_WAIT;
          end
        end
      end
      // refresh pair; after both, fall back through pre2 to finish
      ST_REF: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (ref_cnt_ff != 2'd2) begin
            nxt_cmd.cmd = DDRINI_CMD_REF;                  // second refresh
            cnt_val     = 23'(DDRINI_TRFC_CYC);
          end else if (!pre2_done_ff) begin
            nxt_state   = ST_PRE2;
            nxt_cmd.cmd = DDRINI_CMD_PRE;
            nxt_cmd.addr[DDRINI_PRECH_ALL_BIT] = 1'b1;
            cnt_val     = 23'(DDRINI_TRP_CYC);
          end else begin
            nxt_state = ST_PRE2;                           // both done, fall to finish
          end
        end
      end
      // optional reload: loop reset cleared, same parameters as before
      ST_MR2: begin
        if (cnt_zero) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        nxt_state = ST_DONE;
      end
      // re-lock reuses the mode register and skips refresh and precharge
      ST_DONE: begin
        if (start_ff) begin                                // re-lock after clock change
          nxt_state    = ST_MR;
          nxt_cmd.cmd  = DDRINI_CMD_LMR;
          nxt_cmd.addr = mode_ff;
          nxt_cmd.addr[DDRINI_LOOP_RESET_BIT] = 1'b1;
          cnt_load     = 1'b1;
          cnt_val      = 23'(DDRINI_TMRD_CYC);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // refresh and precharge bookkeeping; cleared on the base mode load after the extended mode, preset on re-lock
  // the refresh count is two bits; re-lock presets it so no third refresh is asked for
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ref_cnt_ff   <= 2'd0;
      pre2_done_ff <= 1'b0;
    end else if (nxt_state == ST_MR && state_ff != ST_MR) begin
      ref_cnt_ff   <= (state_ff == ST_DONE) ? 2'd2 : 2'd0; // re-lock skips refreshes
      pre2_done_ff <= (state_ff == ST_DONE);
    end else begin
      if (nxt_cmd.cmd == DDRINI_CMD_REF) begin
        ref_cnt_ff <= ref_cnt_ff + 2'd1;
      end
      if (state_ff == ST_MR && nxt_state == ST_PRE2 || state_ff == ST_REF && nxt_state == ST_PRE2) begin
        pre2_done_ff <= 1'b1;
      end
    end
  end

  // read holdoff after any loop reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_ff <= 8'h00;
    end else if (nxt_state == ST_MR && state_ff != ST_MR) begin
      lock_ff <= 8'(DDRINI_LOCK_CYC);
    end else if (lock_ff != 8'h00) begin
      lock_ff <= lock_ff - 8'h01;
    end
  end

  // pins: cke low until the wait ends; memory clock runs from start
  // cke never falls again: the device would not take it back as a cmos level
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_mem_cke    <= 1'b0;
      o_mem_clk_en <= 1'b0;
      o_mem_cmd    <= '{cmd: DDRINI_CMD_NOP, bank: 2'b00, addr: 13'h0000};
    end else begin
      if (state_ff == ST_IDLE && start_ff) begin
        o_mem_clk_en <= 1'b1;
      end
      if (state_ff == ST_PWRUP && cnt_zero) begin
        o_mem_cke <= 1'b1;                                 // stays high, device treats as terminated
      end
      o_mem_cmd <= nxt_cmd;
    end
  end

  // user gate: nothing passes before done; reads also wait for lock
  // grant is registered and trails the request by one cycle; users keep req up until granted
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_ready    <= 1'b0;
      o_user_gnt <= 1'b0;
    end else begin
      o_ready    <= (nxt_state == ST_DONE);
      o_user_gnt <= i_user_req & (state_ff == ST_DONE) & ~(i_user_rd & (lock_ff != 8'h00));
    end
  end

  // data strobes are outside this block; lane pairing is by byte
endmodule : ddrini_ctrl

// [ddrini_chk_sva.sv]
module ddrini_chk
  import ddrini_pkg::*;
#(
  parameter int PWRUP_CYC = DDRINI_PWRUP_CYC // power-up wait in cycles
)(
  input  wire logic        i_core_clk,   // clock
  input  wire logic        i_rst,        // sync reset
  input  wire logic        i_user_req,   // user request
  input  wire logic        i_user_rd,    // request is a read
  input  wire logic        o_user_gnt,   // grant
  input  wire logic        o_ready,      // init done
  input  wire logic        o_mem_cke,    // clock enable
  input  wire logic        o_mem_clk_en, // memory clock running
  input  wire ddrini_cmd_s o_mem_cmd     // command bus
);
  logic [15:0] pw_ff; // cycles of running clock with cke low
  logic [7:0]  lk_ff; // cycles since loop reset, saturating
  wire logic   nop = o_mem_cmd.cmd == DDRINI_CMD_NOP;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // saturate so a very long quiet time cannot wrap back below the limit
  always_ff @(posedge i_core_clk) begin
    if (i_rst || o_mem_cke || !o_mem_clk_en) pw_ff <= 16'h0000;
    else if (pw_ff != 16'hFFFF) pw_ff <= pw_ff + 16'h0001;
  end

  // restarted by every base mode load that resets the loop
  always_ff @(posedge i_core_clk) begin
    if (i_rst) lk_ff <= 8'h00;
    else if (o_mem_cmd.cmd == DDRINI_CMD_LMR && o_mem_cmd.bank == 2'h0 && o_mem_cmd.addr[8]) lk_ff <= 8'h01;
    else if (lk_ff != 8'hFF) lk_ff <= lk_ff + 8'h01;
  end

  clk_first_a: assert property (o_mem_cke |-> o_mem_clk_en)
    else $error("clock enable high without memory clock");
  quiet_cmd_a: assert property (!o_mem_cke |-> nop)
    else $error("command while clock enable low");
  pwrup_wait_a: assert property ($rose(o_mem_cke) |-> pw_ff >= PWRUP_CYC)
    else $error("clock enable raised too early");
  cke_nop_a: assert property ($rose(o_mem_cke) |-> nop ##1 nop)
    else $error("no idle command after clock enable rise");
  pre_all_a: assert property (o_mem_cmd.cmd == DDRINI_CMD_PRE |-> o_mem_cmd.addr[10] ##1 nop)
    else $error("precharge not all banks or no idle gap");
  emr_bits_a: assert property (o_mem_cmd.cmd == DDRINI_CMD_LMR && o_mem_cmd.bank == 2'h1
    |-> o_mem_cmd.addr[12:2] == 11'h000 && !o_mem_cmd.addr[0]) else $error("bad extended mode value");
  mrd_gap_a: assert property (o_mem_cmd.cmd == DDRINI_CMD_LMR |=> nop)
    else $error("no idle gap after mode load");
  rfc_gap_a: assert property (o_mem_cmd.cmd == DDRINI_CMD_REF |=> nop[*2])
    else $error("refresh gap too short");
  read_hold_a: assert property (o_user_gnt && $past(i_user_rd) |-> lk_ff >= 8'hC8)
    else $error("read granted inside loop holdoff");
  user_gate_a: assert property (o_user_gnt |-> $past(o_ready) && $past(i_user_req))
    else $error("grant without ready request");
endmodule : ddrini_chk

// [ddrini_mem_model.sv]
module ddrini_mem
  import ddrini_pkg::*;
(
  input  wire logic        i_core_clk, // clock
  input  wire logic        i_rst,      // stands in for a power cycle
  input  wire logic        i_cke,      // clock enable
  input  wire ddrini_cmd_s i_cmd,      // command bus
  output logic             o_done,     // init complete
  output logic [7:0]       o_errs,     // order errors seen
  output logic [12:0]      o_emr,      // extended mode value
  output logic [12:0]      o_mr        // base mode value
);
  logic [1:0] pre_n, ref_n, lmr_n;
  logic       term_ff; // cke now a terminated input
  logic       bad;
  wire logic  go = i_cke && i_cmd.cmd != DDRINI_CMD_NOP;
  wire logic [3:0] c = i_cmd.cmd;
  assign o_done = pre_n == 2'h2 && ref_n == 2'h2;

  // order check; refreshes are legal on either side of the second precharge
  always_comb begin
    bad = term_ff && !i_cke;
    if (go && c == DDRINI_CMD_PRE)
      bad |= !i_cmd.addr[10] || !((pre_n == 2'h0 && lmr_n == 2'h0) || (pre_n == 2'h1 && lmr_n == 2'h2));
    if (go && c == DDRINI_CMD_LMR && i_cmd.bank == 2'h1) bad |= pre_n != 2'h1 || lmr_n != 2'h0;
    else if (go && c == DDRINI_CMD_LMR && lmr_n == 2'h1) bad |= !i_cmd.addr[8];
    else if (go && c == DDRINI_CMD_LMR)
      bad |= !o_done || (i_cmd.addr & 13'h1EFF) != (o_mr & 13'h1EFF);
    if (go && c == DDRINI_CMD_REF) bad |= lmr_n != 2'h2;
  end

  // mode values are kept so the bench can compare them
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      {pre_n, ref_n, lmr_n, term_ff, o_errs, o_emr, o_mr} <= '0;
    end else begin
      if (i_cke) term_ff <= 1'b1;
      if (bad) o_errs <= o_errs + 8'h01;
      if (go && c == DDRINI_CMD_PRE && pre_n != 2'h2) pre_n <= pre_n + 2'h1;
      if (go && c == DDRINI_CMD_REF && ref_n != 2'h2) ref_n <= ref_n + 2'h1;
      if (go && c == DDRINI_CMD_LMR && i_cmd.bank == 2'h1) begin
        o_emr <= i_cmd.addr;
        lmr_n <= 2'h1;
      end else if (go && c == DDRINI_CMD_LMR && lmr_n == 2'h1) begin
        o_mr <= i_cmd.addr;
        lmr_n <= 2'h2;
      end
    end
  end
endmodule : ddrini_mem

// [tb.sv]
module tb
  import ddrini_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_core_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, req = 1'b0, rd = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rdat;
  logic        pready, pslverr, perr, gnt, rdy, cke, clken, mdone;
  ddrini_cmd_s cmd;
  logic [7:0]  merrs;
  logic [12:0] memr, mmr;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;

  always #25 i_core_clk = ~i_core_clk;

  ddrini_ctrl #(.PWRUP_CYC(20)) uut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_user_req(req), .i_user_rd(rd), .o_user_gnt(gnt), .o_ready(rdy), .o_mem_cke(cke), .o_mem_clk_en(clken),
    .o_mem_cmd(cmd));
  ddrini_mem mem (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cke(cke), .i_cmd(cmd), .o_done(mdone),
    .o_errs(merrs), .o_emr(memr), .o_mr(mmr));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; waits on pready, the global timeout bounds it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    pen <= 1'b1;
    do @(posedge i_core_clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // one-cycle user request, grant looked at in the cycle after
  task automatic user(input logic r, input logic exp, input string nm);
    @(posedge i_core_clk);
    req <= 1'b1;
    rd <= r;
    @(posedge i_core_clk);
    req <= 1'b0;
    @(posedge i_core_clk);
    chk(nm, {31'h0, exp}, {31'h0, gnt});
  endtask : user

  task automatic wait_stat(input int n);
    do apb(1'b0, DDRINI_STAT_OFF, 32'h0); while (rdat[n] !== 1'b1);
  endtask : wait_stat

  // ends a hang through the same closing report
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    apb(1'b0, DDRINI_MODE_OFF, 32'h0);
    chk("mode reset", 32'h0022, rdat);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, rdat);
    apb(1'b1, DDRINI_MODE_OFF, 32'h0031);
    user(1'b0, 1'b0, "grant before init");
    apb(1'b1, DDRINI_CTRL_OFF, 32'h000B);
    apb(1'b1, DDRINI_MODE_OFF, 32'h0055);
    wait_stat(10);
    chk("ready pin", 32'h1, {31'h0, rdy});
    chk("memory clock", 32'h1, {31'h0, clken});
    chk("clock enable", 32'h1, {31'h0, cke});
    apb(1'b0, DDRINI_MODE_OFF, 32'h0);
    chk("mode kept", 32'h0031, rdat);
    chk("model done", 32'h1, {31'h0, mdone});
    chk("extended mode", 32'h0002, {19'h0, memr});
    chk("base mode", 32'h0131, {19'h0, mmr});
    user(1'b1, 1'b0, "read in holdoff");
    user(1'b0, 1'b1, "write grant");
    wait_stat(11);
    user(1'b1, 1'b1, "read after lock");
    apb(1'b0, DDRINI_MODE_OFF, 32'h0);
    chk("mode after write", 32'h0031, rdat);
    chk("order errors", 32'h0, {24'h0, merrs});
    i_rst <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    chk("cke after reset", 32'h0, {31'h0, cke});
    chk("ready after reset", 32'h0, {31'h0, rdy});
    apb(1'b1, DDRINI_CTRL_OFF, 32'h0005);
    wait_stat(10);
    chk("early refresh done", 32'h1, {31'h0, mdone});
    chk("normal drive", 32'h0000, {19'h0, memr});
    chk("base mode reset", 32'h0122, {19'h0, mmr});
    wait_stat(11);
    apb(1'b1, DDRINI_CTRL_OFF, 32'h0010);
    user(1'b1, 1'b0, "read after relock");
    wait_stat(11);
    user(1'b1, 1'b1, "read after relock wait");
    chk("order errors", 32'h0, {24'h0, merrs});
    stop_test();
  end
endmodule : tb

bind ddrini_ctrl ddrini_chk #(.PWRUP_CYC(PWRUP_CYC)) chk_i (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_user_req(i_user_req), .i_user_rd(i_user_rd), .o_user_gnt(o_user_gnt), .o_ready(o_ready),
  .o_mem_cke(o_mem_cke), .o_mem_clk_en(o_mem_clk_en), .o_mem_cmd(o_mem_cmd));
